// ==== ssm_regs.vh ====
// Register map, field layout, reset values and timing counts of the safe speed monitor
`ifndef SSM_REGS_VH
`define SSM_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (per instance block of 0x40 bytes)
// ----------------------------------------------------------------------------
`define SSM_INST_STRIDE     8'h40
`define SSM_REG_CTRL        8'h00
`define SSM_REG_MON_DLY     8'h04
`define SSM_REG_RAMP_TIME   8'h08
`define SSM_REG_OVR_TIME    8'h0C
`define SSM_REG_RAMP_DLY    8'h10
`define SSM_REG_MRAMP_DLY   8'h14
`define SSM_REG_UPPER       8'h18
`define SSM_REG_LOWER       8'h1C
`define SSM_REG_FACTOR      8'h20
`define SSM_REG_SOFFSET     8'h24
`define SSM_REG_LOFFSET     8'h28
`define SSM_REG_STATUS      8'h2C
`define SSM_REG_CUR_UPPER   8'h30
`define SSM_REG_CUR_LOWER   8'h34
`define SSM_REG_SPEED       8'h38

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define SSM_CTRL_ACTIVATE   0
`define SSM_CTRL_ACT_LIMIT  1
`define SSM_CTRL_AUTO_RST   2
`define SSM_CTRL_QSTOP      3
`define SSM_CTRL_RAMP_EN    4
`define SSM_ST_REQUEST      0
`define SSM_ST_MONITOR      1
`define SSM_ST_SAFE         2
`define SSM_ST_VIOL         3
`define SSM_ST_OUTSIDE      4

// ----------------------------------------------------------------------------
// Reset values (times in monitor ticks of 100 us)
// ----------------------------------------------------------------------------
`define SSM_TICK_NS         100000
`define SSM_TICK_CYC        (`SSM_TICK_NS / 8)
`define SSM_RST_CTRL        5'h10
`define SSM_RST_MON_DLY     16'h0014
`define SSM_RST_RAMP_TIME   16'h003E
`define SSM_RST_OVR_TIME    16'h0064
`define SSM_RST_RAMP_DLY    16'h003C
`define SSM_MIN_RAMP_DLY    16'h003C
`define SSM_RST_FACTOR      16'h0100
`define SSM_RST_LIMIT       16'h0000

`endif

// ==== ssm_channel.v ====
// One safe speed monitoring channel
`timescale 1ns/1ps
`include "ssm_regs.vh"
module ssm_channel
(
	input  wire        clk_sys,        // System clock
	input  wire        rst,            // Async reset, high
	input  wire        tick,           // Monitor cycle enable
	input  wire        usf_req,        // Parent function request
	input  wire [4:0]  ctrl,           // Control bits
	input  wire [15:0] mon_dly,        // Monitoring start delay
	input  wire [15:0] ramp_time,      // Slowdown ramp time
	input  wire [15:0] ovr_time,       // Allowable overrun time
	input  wire [15:0] ramp_dly,       // Ramp start delay
	input  wire [15:0] mramp_dly,      // Monitor ramp delay
	input  wire signed [15:0] upper_lim, // Final upper limit
	input  wire signed [15:0] lower_lim, // Final lower limit
	input  wire [15:0] factor,         // Start factor, 8.8
	input  wire [15:0] soffset,        // Start offset
	input  wire [15:0] loffset,        // Basic unit limit offset
	input  wire signed [15:0] speed,   // Actual speed
	output reg  [4:0]  status_ff,      // Status bits
	output reg  signed [15:0] mon_up_ff, // Monitored upper bound
	output reg  signed [15:0] mon_lo_ff, // Monitored lower bound
	output reg  signed [15:0] bu_up_ff,  // Basic unit upper limit
	output reg  signed [15:0] bu_lo_ff,  // Basic unit lower limit
	output reg         bu_lim_en_ff,   // Basic unit limiting active
	output reg         qstop_ff        // Quick stop command
);
	reg               req_ff;
	reg        [15:0] t_ff;
	reg        [15:0] ovr_ff;
	reg signed [15:0] st_up_ff;
	reg signed [15:0] st_lo_ff;
	reg               outside_ff;

	wire        [15:0] rdly_eff = (ramp_dly < `SSM_MIN_RAMP_DLY) ? `SSM_MIN_RAMP_DLY : ramp_dly;
	wire        [16:0] ms_start = {1'b0, rdly_eff} + {1'b0, mramp_dly};
	wire        [16:0] ms_end   = {1'b0, ramp_time} + {1'b0, mramp_dly};
	wire        [16:0] t_ext    = {1'b0, t_ff};
	wire signed [31:0] scaled   = (speed * $signed({1'b0, factor})) >>> 8;
	// Wide enough for full speed times largest factor, so saturation works
	wire signed [24:0] sc       = scaled[24:0];
	wire signed [24:0] so       = $signed({9'h000, soffset});
	wire signed [24:0] cu_raw   = (speed >= 16'sh0000) ? sc + so : 25'sh000_0000;
	wire signed [24:0] cl_raw   = (speed <  16'sh0000) ? sc - so : 25'sh000_0000;
	wire signed [15:0] cu       = (cu_raw > 25'sh000_7FFF) ? 16'sh7FFF :
		(cu_raw < $signed({{9{upper_lim[15]}}, upper_lim})) ? upper_lim : cu_raw[15:0];
	wire signed [15:0] cl       = (cl_raw < -25'sh000_8000) ? 16'sh8000 :
		(cl_raw > $signed({{9{lower_lim[15]}}, lower_lim})) ? lower_lim : cl_raw[15:0];
	wire        [16:0] span     = (ms_end > ms_start) ? ms_end - ms_start : 17'd1;
	wire        [16:0] el       = (t_ext <= ms_start) ? 17'd0 : t_ext - ms_start;
	// Ticks left on the ramp: bound starts at the start value, ends at the limit
	wire        [16:0] rem      = (el >= span) ? 17'h0_0000 : span - el;
	wire signed [33:0] dup      = ($signed({st_up_ff[15], st_up_ff}) - upper_lim) *
		$signed({1'b0, rem});
	wire signed [33:0] dlo      = ($signed({st_lo_ff[15], st_lo_ff}) - lower_lim) *
		$signed({1'b0, rem});
	wire signed [33:0] qup      = dup / $signed({1'b0, span});
	wire signed [33:0] qlo      = dlo / $signed({1'b0, span});
	wire signed [15:0] rup      = upper_lim + $signed(qup[15:0]);
	wire signed [15:0] rlo      = lower_lim + $signed(qlo[15:0]);
	wire               ramp_on  = ctrl[`SSM_CTRL_RAMP_EN];
	wire               done     = !ramp_on ? (t_ext >= ms_start) : (t_ext >= ms_end);
	wire signed [15:0] nxt_up   = (t_ext < ms_start) ? st_up_ff : (done ? upper_lim : rup);
	wire signed [15:0] nxt_lo   = (t_ext < ms_start) ? st_lo_ff : (done ? lower_lim : rlo);
	wire               monitor  = req_ff && (t_ext >= {1'b0, mon_dly}) && (t_ext >= ms_start);
	wire               out_now  = (speed > mon_up_ff) || (speed < mon_lo_ff);
	wire signed [16:0] bu_u     = $signed({mon_up_ff[15], mon_up_ff}) - $signed({1'b0, loffset});
	wire signed [16:0] bu_l     = $signed({mon_lo_ff[15], mon_lo_ff}) + $signed({1'b0, loffset});
	wire signed [16:0] bu_mean  = ($signed({mon_up_ff[15], mon_up_ff}) + mon_lo_ff) >>> 1;
	wire               new_req  = usf_req && ctrl[`SSM_CTRL_ACTIVATE] && !req_ff;

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			req_ff       <= 1'b0;
			t_ff         <= 16'h0000;
			ovr_ff       <= 16'h0000;
			st_up_ff     <= 16'sh7FFF;
			st_lo_ff     <= 16'sh8000;
			mon_up_ff    <= 16'sh7FFF;
			mon_lo_ff    <= 16'sh8000;
			bu_up_ff     <= 16'sh7FFF;
			bu_lo_ff     <= 16'sh8000;
			bu_lim_en_ff <= 1'b0;
			qstop_ff     <= 1'b0;
			outside_ff   <= 1'b0;
			status_ff    <= 5'h00;
		end
		else if (tick)
		begin
			if (new_req)
			begin
				req_ff   <= 1'b1;
				t_ff     <= 16'h0000;
				st_up_ff <= cu;
				st_lo_ff <= cl;
				mon_up_ff <= cu;
				mon_lo_ff <= cl;
			end
			else if (req_ff && !usf_req && ctrl[`SSM_CTRL_AUTO_RST])
			begin
				req_ff    <= 1'b0;
				mon_up_ff <= 16'sh7FFF;
				mon_lo_ff <= 16'sh8000;
			end
			else if (req_ff)
			begin
				if (t_ff != 16'hFFFF)
					t_ff <= t_ff + 16'h0001;
				mon_up_ff <= nxt_up;
				mon_lo_ff <= nxt_lo;
			end
			// Overrun filter; sets and clears both need a full interval
			outside_ff <= monitor && out_now;
			if (!monitor)
				ovr_ff <= 16'h0000;
			else if ((out_now != status_ff[`SSM_ST_VIOL]) && (ovr_ff < ovr_time))
				ovr_ff <= ovr_ff + 16'h0001;
			else if (out_now != status_ff[`SSM_ST_VIOL])
			begin
				ovr_ff <= 16'h0000;
				status_ff[`SSM_ST_VIOL] <= out_now;
			end
			else
				ovr_ff <= 16'h0000;
			status_ff[`SSM_ST_REQUEST] <= req_ff;
			status_ff[`SSM_ST_MONITOR] <= monitor;
			status_ff[`SSM_ST_SAFE]    <= req_ff && done && !out_now;
			status_ff[`SSM_ST_OUTSIDE] <= outside_ff;
			bu_lim_en_ff <= req_ff && ctrl[`SSM_CTRL_ACT_LIMIT];
			qstop_ff     <= req_ff && ctrl[`SSM_CTRL_QSTOP];
			if (bu_u < bu_l)
			begin
				bu_up_ff <= bu_mean[15:0];
				bu_lo_ff <= bu_mean[15:0];
			end
			else
			begin
				bu_up_ff <= bu_u[15:0];
				bu_lo_ff <= bu_l[15:0];
			end
		end
	end
endmodule // ssm_channel

// ==== ssm_top.v ====
// Safe speed monitor: four channels behind an AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ssm_regs.vh"
module ssm_top
#(
	parameter NCH      = 4,              // Instance count
	parameter TICK_CYC = `SSM_TICK_CYC   // Clocks per monitor cycle
)
(
	input  wire            clk_sys,      // System clock, 125 MHz
	input  wire            rst,          // Async reset, high
	input  wire            hsel,         // AHB select
	input  wire [31:0]     haddr,        // AHB address
	input  wire [1:0]      htrans,       // AHB transfer type
	input  wire            hwrite,       // AHB write
	input  wire [2:0]      hsize,        // AHB size
	input  wire [31:0]     hwdata,       // AHB write data
	input  wire            hready,       // AHB bus ready
	output wire [31:0]     hrdata,       // AHB read data
	output wire            hreadyout,    // AHB slave ready
	output wire            hresp,        // AHB response
	input  wire [NCH-1:0]  usf_req,      // Parent function requests
	input  wire [16*NCH-1:0] speed,      // Actual speeds per instance
	output wire [NCH-1:0]  viol,         // Violation flags
	output wire [NCH-1:0]  safe_reached, // Safe state reached
	output wire [NCH-1:0]  qstop,        // Quick stop commands
	output wire [NCH-1:0]  bu_lim_en,    // Basic unit limiting on
	output wire [16*NCH-1:0] bu_upper,   // Basic unit upper limits
	output wire [16*NCH-1:0] bu_lower    // Basic unit lower limits
);
	// ------------------------------------------------------------------------
	// Monitor cycle divider
	// ------------------------------------------------------------------------
	reg  [15:0] div_ff;
	reg         tick_ff;
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			div_ff  <= 16'h0000;
			tick_ff <= 1'b0;
		end
		else if (div_ff == TICK_CYC - 1)
		begin
			div_ff  <= 16'h0000;
			tick_ff <= 1'b1;
		end
		else
		begin
			div_ff  <= div_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// AHB-Lite address phase capture
	// ------------------------------------------------------------------------
	reg         wr_ff;
	reg  [7:0]  wa_ff;
	reg  [31:0] rdata_ff;
	wire        acc     = hsel && htrans[1] && hready;
	wire [1:0]  a_ch    = haddr[7:6];
	wire [7:0]  a_reg   = {2'b00, haddr[5:0]};

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;

	// ------------------------------------------------------------------------
	// Per instance registers and channel
	// ------------------------------------------------------------------------
	wire [32*NCH-1:0] rd_bus;
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : g_ch
			reg  [4:0]  ctrl_ff;
			reg  [15:0] mon_dly_ff;
			reg  [15:0] ramp_time_ff;
			reg  [15:0] ovr_time_ff;
			reg  [15:0] ramp_dly_ff;
			reg  [15:0] mramp_dly_ff;
			reg  [15:0] upper_ff;
			reg  [15:0] lower_ff;
			reg  [15:0] factor_ff;
			reg  [15:0] soffset_ff;
			reg  [15:0] loffset_ff;
			reg  [31:0] rd;
			wire [4:0]  st;
			wire [15:0] mu;
			wire [15:0] ml;
			wire [15:0] spd = speed[16*g +: 16];
			wire        sel = wr_ff && (wa_ff[7:6] == g);

			always @(posedge clk_sys or posedge rst)
			begin
				if (rst)
				begin
					ctrl_ff      <= `SSM_RST_CTRL;
					mon_dly_ff   <= `SSM_RST_MON_DLY;
					ramp_time_ff <= `SSM_RST_RAMP_TIME;
					ovr_time_ff  <= `SSM_RST_OVR_TIME;
					ramp_dly_ff  <= `SSM_RST_RAMP_DLY;
					mramp_dly_ff <= 16'h0000;
					upper_ff     <= `SSM_RST_LIMIT;
					lower_ff     <= `SSM_RST_LIMIT;
					factor_ff    <= `SSM_RST_FACTOR;
					soffset_ff   <= 16'h0000;
					loffset_ff   <= 16'h0000;
				end
				else if (sel)
				begin
					case ({2'b00, wa_ff[5:0]})
						`SSM_REG_CTRL:      ctrl_ff      <= hwdata[4:0];
						`SSM_REG_MON_DLY:   mon_dly_ff   <= hwdata[15:0];
						`SSM_REG_RAMP_TIME: ramp_time_ff <= hwdata[15:0];
						`SSM_REG_OVR_TIME:  ovr_time_ff  <= hwdata[15:0];
						`SSM_REG_RAMP_DLY:  ramp_dly_ff  <= (hwdata[15:0] < `SSM_MIN_RAMP_DLY) ?
							`SSM_MIN_RAMP_DLY : hwdata[15:0];
						`SSM_REG_MRAMP_DLY: mramp_dly_ff <= hwdata[15:0];
						`SSM_REG_UPPER:     upper_ff     <= hwdata[15:0];
						`SSM_REG_LOWER:     lower_ff     <= hwdata[15:0];
						`SSM_REG_FACTOR:    factor_ff    <= hwdata[15:0];
						`SSM_REG_SOFFSET:   soffset_ff   <= hwdata[15:0];
						`SSM_REG_LOFFSET:   loffset_ff   <= hwdata[15:0];
						default:            ctrl_ff      <= ctrl_ff;
					endcase
				end
			end

			ssm_channel u_ch
			(
				.clk_sys      (clk_sys),
				.rst          (rst),
				.tick         (tick_ff),
				.usf_req      (usf_req[g]),
				.ctrl         (ctrl_ff),
				.mon_dly      (mon_dly_ff),
				.ramp_time    (ramp_time_ff),
				.ovr_time     (ovr_time_ff),
				.ramp_dly     (ramp_dly_ff),
				.mramp_dly    (mramp_dly_ff),
				.upper_lim    (upper_ff),
				.lower_lim    (lower_ff),
				.factor       (factor_ff),
				.soffset      (soffset_ff),
				.loffset      (loffset_ff),
				.speed        (spd),
				.status_ff    (st),
				.mon_up_ff    (mu),
				.mon_lo_ff    (ml),
				.bu_up_ff     (bu_upper[16*g +: 16]),
				.bu_lo_ff     (bu_lower[16*g +: 16]),
				.bu_lim_en_ff (bu_lim_en[g]),
				.qstop_ff     (qstop[g])
			);

			assign viol[g]         = st[`SSM_ST_VIOL];
			assign safe_reached[g] = st[`SSM_ST_SAFE];

			always @*
			begin
				case (a_reg)
					`SSM_REG_CTRL:      rd = {27'h000_0000, ctrl_ff};
					`SSM_REG_MON_DLY:   rd = {16'h0000, mon_dly_ff};
					`SSM_REG_RAMP_TIME: rd = {16'h0000, ramp_time_ff};
					`SSM_REG_OVR_TIME:  rd = {16'h0000, ovr_time_ff};
					`SSM_REG_RAMP_DLY:  rd = {16'h0000, ramp_dly_ff};
					`SSM_REG_MRAMP_DLY: rd = {16'h0000, mramp_dly_ff};
					`SSM_REG_UPPER:     rd = {16'h0000, upper_ff};
					`SSM_REG_LOWER:     rd = {16'h0000, lower_ff};
					`SSM_REG_FACTOR:    rd = {16'h0000, factor_ff};
					`SSM_REG_SOFFSET:   rd = {16'h0000, soffset_ff};
					`SSM_REG_LOFFSET:   rd = {16'h0000, loffset_ff};
					`SSM_REG_STATUS:    rd = {27'h000_0000, st};
					`SSM_REG_CUR_UPPER: rd = {16'h0000, mu};
					`SSM_REG_CUR_LOWER: rd = {16'h0000, ml};
					`SSM_REG_SPEED:     rd = {16'h0000, spd};
					default:            rd = 32'h0000_0000;
				endcase
			end
			assign rd_bus[32*g +: 32] = rd;
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Bus phase registers
	// ------------------------------------------------------------------------
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wr_ff    <= 1'b0;
			wa_ff    <= 8'h00;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			wr_ff <= acc && hwrite;
			if (acc)
				wa_ff <= haddr[7:0];
			if (acc && !hwrite)
				rdata_ff <= rd_bus[32*a_ch +: 32];
		end
	end
endmodule // ssm_top

// ==== ssm_checker_assertions.sv ====
// Port-level concurrent checks for the safe speed monitor
`timescale 1ns/1ps
module ssm_checker
#(
	parameter NCH      = 4, // Instance count
	parameter TICK_CYC = 4  // Clocks per monitor cycle
)
(
	input wire               clk_sys,      // System clock
	input wire               rst,          // Async reset, high
	input wire               hsel,         // AHB select
	input wire [1:0]         htrans,       // AHB transfer type
	input wire               hwrite,       // AHB write
	input wire               hready,       // AHB bus ready
	input wire [31:0]        hrdata,       // AHB read data
	input wire               hreadyout,    // AHB slave ready
	input wire               hresp,        // AHB response
	input wire [NCH-1:0]     usf_req,      // Parent requests
	input wire [NCH-1:0]     viol,         // Violation flags
	input wire [NCH-1:0]     safe_reached, // Safe state flags
	input wire [NCH-1:0]     qstop,        // Quick stop lines
	input wire [NCH-1:0]     bu_lim_en,    // Limiting active
	input wire [16*NCH-1:0]  bu_upper,     // Basic unit upper limits
	input wire [16*NCH-1:0]  bu_lower      // Basic unit lower limits
);
// ----------------------------------------------------------------------------
// Request history
// ----------------------------------------------------------------------------
// Earliest start of monitoring, less one tick of phase slack
localparam MIN_MON = 59 * TICK_CYC;
reg [NCH-1:0] req_seen_ff;
reg [31:0]    req_cnt_ff;
always @(posedge clk_sys or posedge rst)
begin
	if (rst)
	begin
		req_seen_ff <= '0;
		req_cnt_ff  <= '0;
	end
	else
	begin
		req_seen_ff <= req_seen_ff | usf_req;
		if (|req_seen_ff)
			req_cnt_ff <= req_cnt_ff + 32'd1;
	end
end
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
// ----------------------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------------------
a_ready_always: assert property (hreadyout) else $error("hreadyout low");
a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
a_hrdata_hold: assert property (!$past(hsel && htrans[1] && hready && !hwrite)
	|-> $stable(hrdata)) else $error("hrdata moved without a read");
a_qstop_cause: assert property ((qstop & ~$past(qstop) & ~(req_seen_ff | usf_req)) == '0)
	else $error("quick stop without request");
a_limit_cause: assert property ((bu_lim_en & ~$past(bu_lim_en) & ~(req_seen_ff | usf_req)) == '0)
	else $error("limiting without request");
a_safe_cause: assert property ((safe_reached & ~req_seen_ff & ~usf_req) == '0)
	else $error("safe state without request");
a_viol_delay: assert property ((viol & ~$past(viol)) != '0 |-> req_cnt_ff >= MIN_MON)
	else $error("violation before monitoring start");
a_viol_hold: assert property ($rose(viol[0]) |=> viol[0] [*3])
	else $error("violation cleared within a tick");
a_safe_pace: assert property ($changed(safe_reached) |=> $stable(safe_reached) [*3])
	else $error("safe flag changed between ticks");
a_bu_order: assert property ($signed(bu_upper[15:0]) >= $signed(bu_lower[15:0]))
	else $error("basic unit limits crossed");
endmodule // ssm_checker

bind ssm_top ssm_checker #(.NCH(NCH), .TICK_CYC(TICK_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .usf_req(usf_req), .viol(viol),
	.safe_reached(safe_reached), .qstop(qstop), .bu_lim_en(bu_lim_en),
	.bu_upper(bu_upper), .bu_lower(bu_lower));

// ==== ssm_drive_model.sv ====
// Basic unit drive model: follows a setpoint within limits, stops on quick stop
`timescale 1ns/1ps
module ssm_drive_model
#(
	parameter NCH = 4 // Instance count
)
(
	input  wire              clk_sys,   // System clock
	input  wire [16*NCH-1:0] setpt,     // Commanded speeds
	input  wire [NCH-1:0]    qstop,     // Quick stop lines
	input  wire [NCH-1:0]    bu_lim_en, // Limiting active
	input  wire [16*NCH-1:0] bu_upper,  // Upper limits
	input  wire [16*NCH-1:0] bu_lower,  // Lower limits
	output reg  [16*NCH-1:0] speed = '0 // Actual speeds
);
function automatic [15:0] follow(input signed [15:0] s, u, l, input q, e);
	if (q)
		follow = 16'h0000;
	else if (e && s > u)
		follow = u;
	else if (e && s < l)
		follow = l;
	else
		follow = s;
endfunction
always @(posedge clk_sys)
	for (int n = 0; n < NCH; n++)
		speed[16*n+:16] <= follow(setpt[16*n+:16], bu_upper[16*n+:16],
			bu_lower[16*n+:16], qstop[n], bu_lim_en[n]);
endmodule // ssm_drive_model

// ==== testbench.sv ====
// Self-checking bench for the safe speed monitor
`timescale 1ns/1ps
module testbench;
localparam TC = 4;
reg          clk_sys = 0;
reg          rst     = 1;
reg          hsel    = 0;
reg  [31:0]  haddr   = 0;
reg  [1:0]   htrans  = 0;
reg          hwrite  = 0;
reg  [2:0]   hsize   = 3'h2;
reg  [31:0]  hwdata  = 0;
reg  [3:0]   usf_req = 0;
reg  [63:0]  setpt   = {4{16'h0032}};
wire [31:0]  hrdata;
wire         hreadyout;
wire         hresp;
wire         hready = hreadyout;
wire [63:0]  speed, bu_upper, bu_lower;
wire [3:0]   viol, safe_reached, qstop, bu_lim_en;
int          n_errors = 0;
int          checked  = 0;
logic [31:0] rd;
logic [7:0]  ctrl_tab [4] = '{8'h01, 8'h00, 8'h1B, 8'h17};
always #4 clk_sys = ~clk_sys;
ssm_top #(.NCH(4), .TICK_CYC(TC)) i_dut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .usf_req, .speed, .viol,
	.safe_reached, .qstop, .bu_lim_en, .bu_upper, .bu_lower);
ssm_drive_model #(.NCH(4)) u_drive (.clk_sys, .setpt, .qstop, .bu_lim_en, .bu_upper,
	.bu_lower, .speed);
// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
	checked++;
	if (got !== exp)
	begin
		$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		n_errors++;
	end
endtask
task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
	@(posedge clk_sys);
	hsel <= 1;
	haddr <= a;
	hwrite <= w;
	htrans <= 2'b10;
	do @(posedge clk_sys); while (hready !== 1'b1);
	hsel <= 0;
	htrans <= 2'b00;
	hwdata <= d;
	do @(posedge clk_sys); while (hready !== 1'b1);
	rd = hrdata;
endtask
task rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
	bus(0, a, 0);
	chk(nm, exp, rd);
endtask
task give_verdict;
	$display("%0d comparisons, %0d mismatches", checked, n_errors);
	if (n_errors == 0 && checked > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
// ----------------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------------
task t_regs;
	rchk("ctrl reset", 32'h0000_0000, 32'h0000_0010);
	rchk("mon_dly reset", 32'h0000_0004, 32'h0000_0014);
	rchk("ramp_time reset", 32'h0000_0008, 32'h0000_003E);
	rchk("ovr reset inst3", 32'h0000_00CC, 32'h0000_0064);
	rchk("unmapped", 32'h0000_003C, 32'h0000_0000);
	bus(1, 32'h0000_0010, 32'h0000_000A);
	rchk("ramp_dly floor", 32'h0000_0010, 32'h0000_003C);
	bus(1, 32'h0000_0038, 32'h0000_1234);
	rchk("speed read only", 32'h0000_0038, 32'h0000_0032);
	$display("test regs done");
endtask
task t_setup;
	for (int n = 0; n < 4; n++)
	begin
		bus(1, n * 64 + 4, 32'h0000_0014);
		bus(1, n * 64 + 8, 32'h0000_003E);
		bus(1, n * 64 + 12, 32'h0000_0005);
		bus(1, n * 64 + 24, 32'h0000_0064);
		bus(1, n * 64 + 28, 32'h0000_FF9C);
		bus(1, n * 64 + 40, (n == 2) ? 32'h0000_0096 : 32'h0000_000A);
		bus(1, n * 64, {24'h0, ctrl_tab[n]});
	end
	rchk("ctrl inst2", 32'h0000_0080, 32'h0000_001B);
	$display("test setup done");
endtask
task t_request;
	@(posedge clk_sys);
	usf_req <= 4'hF;
	repeat (150 * TC) @(posedge clk_sys);
	@(negedge clk_sys);
	chk("safe_reached", 4'b1101, safe_reached);
	chk("qstop", 4'b0100, qstop);
	chk("bu_lim_en", 4'b1100, bu_lim_en);
	chk("bu_upper2", 16'h0000, bu_upper[47:32]);
	chk("bu_lower2", 16'h0000, bu_lower[47:32]);
	chk("bu_upper3", 16'h005A, bu_upper[63:48]);
	chk("bu_lower3", 32'h0000_FFA6, bu_lower[63:48]);
	chk("viol idle", 4'b0000, viol);
	rchk("status inst1", 32'h0000_006C, 32'h0000_0000);
	rchk("status inst0", 32'h0000_002C, 32'h0000_0007);
	rchk("cur upper", 32'h0000_0030, 32'h0000_0064);
	rchk("cur lower", 32'h0000_0034, 32'h0000_FF9C);
	$display("test request done");
endtask
task t_viol;
	@(posedge clk_sys);
	setpt[15:0] <= 16'h00C8;
	setpt[63:48] <= 16'h00C8;
	repeat (3 * TC) @(posedge clk_sys);
	@(negedge clk_sys);
	chk("viol early", 1'b0, viol[0]);
	for (int i = 0; i < 10 * TC && viol[0] !== 1'b1; i++) @(posedge clk_sys);
	@(negedge clk_sys);
	chk("viol set", 1'b1, viol[0]);
	chk("viol limited", 1'b0, viol[3]);
	@(posedge clk_sys);
	setpt[15:0] <= 16'h0032;
	repeat (3 * TC) @(posedge clk_sys);
	@(negedge clk_sys);
	chk("viol held", 1'b1, viol[0]);
	for (int i = 0; i < 10 * TC && viol[0] !== 1'b0; i++) @(posedge clk_sys);
	@(negedge clk_sys);
	chk("viol clear", 1'b0, viol[0]);
	$display("test violation done");
endtask
task t_restart;
	@(posedge clk_sys);
	usf_req <= 4'h0;
	repeat (5 * TC) @(posedge clk_sys);
	bus(0, 32'h0000_00EC, 0);
	chk("req inst3", 1'b0, rd[0]);
	bus(0, 32'h0000_002C, 0);
	chk("req inst0", 1'b1, rd[0]);
	$display("test restart done");
endtask
task t_ramp;
	bus(1, 32'h0000_0048, 32'h0000_0046);
	bus(1, 32'h0000_0054, 32'h0000_0004);
	bus(1, 32'h0000_0060, 32'h0000_0200);
	bus(1, 32'h0000_0064, 32'h0000_0014);
	bus(1, 32'h0000_0040, 32'h0000_0011);
	@(posedge clk_sys);
	usf_req <= 4'h2;
	repeat (31 * TC) @(posedge clk_sys);
	rchk("ramp start bound", 32'h0000_0070, 32'h0000_0078);
	repeat (32 * TC) @(posedge clk_sys);
	rchk("ramp held by delays", 32'h0000_0070, 32'h0000_0078);
	repeat (7 * TC) @(posedge clk_sys);
	bus(0, 32'h0000_0070, 0);
	chk("ramp moving", 1, rd > 32'h0000_0064 && rd < 32'h0000_0078);
	repeat (16 * TC) @(posedge clk_sys);
	rchk("ramp end bound", 32'h0000_0070, 32'h0000_0064);
	chk("safe inst1", 1'b1, safe_reached[1]);
	$display("test ramp done");
endtask
initial
begin
	repeat (6) @(posedge clk_sys);
	rst <= 0;
	t_regs;
	t_setup;
	t_request;
	t_viol;
	t_restart;
	t_ramp;
	give_verdict;
end
initial
begin
	repeat (20000) @(posedge clk_sys);
	n_errors++;
	$display("watchdog expired");
	give_verdict;
end
endmodule // testbench
